// ---- hdl/dscg_pkg.sv ----
// constants and helpers shared by the deep-sleep clock gating block
package dscg_pkg;

	// ==========================================================
	// register offsets (byte addresses)
	localparam logic [11:0] OFF_RUN_CLOCK_CONFIG = 12'h060;
	localparam logic [11:0] OFF_RUN_CLOCK_GATE_0 = 12'h100;
	localparam logic [11:0] OFF_SLEEP_CLOCK_GATE_0 = 12'h110;
	localparam logic [11:0] OFF_DEEP_SLEEP_CLOCK_GATE_0 = 12'h120;
	localparam logic [11:0] OFF_IRQ_STATUS = 12'h200;
	localparam logic [11:0] OFF_IRQ_ENABLE = 12'h204;
	localparam logic [11:0] OFF_IRQ_CLEAR = 12'h208;

	// ==========================================================
	// gating register layout
	localparam int BIT_CAN = 24;
	localparam int BIT_PWM = 20;
	localparam int BIT_ADC = 16;
	localparam int BIT_HIB = 6;
	localparam int BIT_WDT = 3;
	localparam logic [31:0] GATE_WR_MASK = 32'h0111_0048;
	localparam logic [31:0] GATE_RESET = 32'h0000_0040;

	// run clock configuration layout
	localparam int BIT_AUTO_GATING_SELECT = 27;

	// ==========================================================
	// unit index in the five-bit enable vector
	localparam int NUM_UNITS = 5;
	localparam logic [2:0] UNIT_WDT = 3'h0;
	localparam logic [2:0] UNIT_HIB = 3'h1;
	localparam logic [2:0] UNIT_ADC = 3'h2;
	localparam logic [2:0] UNIT_PWM = 3'h3;
	localparam logic [2:0] UNIT_CAN = 3'h4;

	// ==========================================================
	// interrupt status layout
	localparam int NUM_IRQ = 2;
	localparam int IRQ_ACCESS_FAULT = 0;
	localparam int IRQ_DEEP_ENTRY = 1;

	// power modes, gray coded along run -> sleep -> deep
	typedef enum logic [1:0] {
		DSCG_RUN = 2'b00,
		DSCG_SLEEP = 2'b01,
		DSCG_DEEP = 2'b11
	} dscg_mode_t;

	// gather the unit enables out of a gating register word
	function automatic logic [NUM_UNITS-1:0] unit_bits(input logic [31:0] r);
		unit_bits = {r[BIT_CAN], r[BIT_PWM], r[BIT_ADC], r[BIT_HIB], r[BIT_WDT]};
	endfunction : unit_bits

endpackage : dscg_pkg

// ---- hdl/dscg_gate_reg.sv ----
// one clock gating register: writable enables, reserved bits held at zero
`timescale 1ns/10ps
module dscg_gate_reg import dscg_pkg::*; (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// write side
	input wire logic wr_en,
	input wire logic [31:0] wr_data,
	// stored value
	output logic [31:0] value_q
);

	// ==========================================================
	// storage
	logic [31:0] value_d;

	// reserved bits can never be set, so reads return zero there
	assign value_d = wr_en ? (wr_data & GATE_WR_MASK) : value_q;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			value_q <= GATE_RESET;
		end else begin
			value_q <= value_d;
		end
	end

endmodule : dscg_gate_reg

// ---- hdl/dscg_mode_sel.sv ----
// picks the gating register in force for the current power mode
`timescale 1ns/10ps
module dscg_mode_sel import dscg_pkg::*; (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// mode and selection
	input wire dscg_mode_t mode,
	input wire logic auto_gate,
	// the three gating registers
	input wire logic [31:0] run_gate,
	input wire logic [31:0] sleep_gate,
	input wire logic [31:0] deep_gate,
	// enables in force
	output logic [NUM_UNITS-1:0] unit_en_q
);

	// ==========================================================
	// selection
	logic [NUM_UNITS-1:0] unit_en_d;

	always_comb begin
		unit_en_d = unit_bits(run_gate);
		if (auto_gate) begin
			case (mode)
				DSCG_RUN: unit_en_d = unit_bits(run_gate);
				DSCG_SLEEP: unit_en_d = unit_bits(sleep_gate);
				DSCG_DEEP: unit_en_d = unit_bits(deep_gate);
				default: unit_en_d = unit_bits(run_gate);
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			unit_en_q <= unit_bits(GATE_RESET);
		end else begin
			unit_en_q <= unit_en_d;
		end
	end

endmodule : dscg_mode_sel

// ---- hdl/dscg_top.sv ----
// deep-sleep clock gating control with run and sleep companions
//
// How it works
// [R01] set bit clocks unit, clear bit stops it
// [R02] access to unclocked unit answers bus fault
// [R03] deep-sleep register resets to 0x00000040
// [R04] bit 6 hibernation enable, resets one
// [R05] bit 3 watchdog enable, faults when clear
// [R06] bit 20 pwm enable, faults when clear
// [R07] bit 24 can, bit 16 adc enables
// [R08] reserved bits read zero; software preserves
// [R09] run, sleep, deep registers share layout
// [R10] sleep/deep apply only with auto select
// [R11] software enables units before using them
`timescale 1ns/10ps
module dscg_top import dscg_pkg::*; (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// register port
	input wire logic [11:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata_q,
	// power mode requests from the system
	input wire logic sleep_req,
	input wire logic deep_sleep_req,
	// peripheral access check
	input wire logic unit_req,
	input wire logic [2:0] unit_id,
	output logic unit_ok_q,
	output logic unit_fault_q,
	// unit clock enables
	output logic can_unit_clock_enable_q,
	output logic pwm_clock_enable_q,
	output logic adc_clock_enable_q,
	output logic hibernation_clock_enable_q,
	output logic watchdog_clock_enable_q,
	// interrupt
	output logic irq_q
);

	// ==========================================================
	// address decode
	logic wr_run_cfg;
	logic wr_run;
	logic wr_sleep;
	logic wr_deep;
	logic wr_irq_en;
	logic wr_irq_clr;

	assign wr_run_cfg = reg_wr && (reg_addr == OFF_RUN_CLOCK_CONFIG);
	assign wr_run = reg_wr && (reg_addr == OFF_RUN_CLOCK_GATE_0);
	assign wr_sleep = reg_wr && (reg_addr == OFF_SLEEP_CLOCK_GATE_0);
	assign wr_deep = reg_wr && (reg_addr == OFF_DEEP_SLEEP_CLOCK_GATE_0);
	assign wr_irq_en = reg_wr && (reg_addr == OFF_IRQ_ENABLE);
	assign wr_irq_clr = reg_wr && (reg_addr == OFF_IRQ_CLEAR);

	// ==========================================================
	// the three gating registers
	logic [31:0] run_clock_gate_0;
	logic [31:0] sleep_clock_gate_0;
	logic [31:0] deep_sleep_clock_gate_0;

	// same module, same layout for all three [R09]
	dscg_gate_reg u_run (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.wr_en(wr_run),
		.wr_data(reg_wdata),
		.value_q(run_clock_gate_0)
	);

	dscg_gate_reg u_sleep (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.wr_en(wr_sleep),
		.wr_data(reg_wdata),
		.value_q(sleep_clock_gate_0)
	);

	// reset word and writable bits come from the shared layout [R03] [R04] [R07]
	dscg_gate_reg u_deep (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.wr_en(wr_deep),
		.wr_data(reg_wdata),
		.value_q(deep_sleep_clock_gate_0)
	);

	// ==========================================================
	// run clock configuration: only the auto gating select is kept
	logic auto_gating_select_q;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			auto_gating_select_q <= 1'b0;
		end else if (wr_run_cfg) begin
			auto_gating_select_q <= reg_wdata[BIT_AUTO_GATING_SELECT];
		end
	end

	// ==========================================================
	// power mode tracking
	dscg_mode_t mode_q;
	dscg_mode_t mode_d;

	// deep sleep outranks sleep when both are asked for
	always_comb begin
		case (mode_q)
			DSCG_RUN: mode_d = deep_sleep_req ? DSCG_DEEP : (sleep_req ? DSCG_SLEEP : DSCG_RUN);
			DSCG_SLEEP: mode_d = deep_sleep_req ? DSCG_DEEP : (sleep_req ? DSCG_SLEEP : DSCG_RUN);
			DSCG_DEEP: mode_d = deep_sleep_req ? DSCG_DEEP : (sleep_req ? DSCG_SLEEP : DSCG_RUN);
			default: mode_d = DSCG_RUN;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_q <= DSCG_RUN;
		end else begin
			mode_q <= mode_d;
		end
	end

	// ==========================================================
	// enables in force
	logic [NUM_UNITS-1:0] unit_en;

	// sleep and deep values only win with auto select set [R10]
	dscg_mode_sel u_sel (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.mode(mode_q),
		.auto_gate(auto_gating_select_q),
		.run_gate(run_clock_gate_0),
		.sleep_gate(sleep_clock_gate_0),
		.deep_gate(deep_sleep_clock_gate_0),
		.unit_en_q(unit_en)
	);

	// one more flop so the pins come straight from registers [R01]
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			can_unit_clock_enable_q <= GATE_RESET[BIT_CAN];
			pwm_clock_enable_q <= GATE_RESET[BIT_PWM];
			adc_clock_enable_q <= GATE_RESET[BIT_ADC];
			hibernation_clock_enable_q <= GATE_RESET[BIT_HIB];
			watchdog_clock_enable_q <= GATE_RESET[BIT_WDT];
		end else begin
			can_unit_clock_enable_q <= unit_en[UNIT_CAN];
			pwm_clock_enable_q <= unit_en[UNIT_PWM];
			adc_clock_enable_q <= unit_en[UNIT_ADC];
			hibernation_clock_enable_q <= unit_en[UNIT_HIB];
			watchdog_clock_enable_q <= unit_en[UNIT_WDT];
		end
	end

	// ==========================================================
	// access check against the enable driven at the pins
	logic [NUM_UNITS-1:0] pin_en;
	logic unit_on;

	assign pin_en = {can_unit_clock_enable_q, pwm_clock_enable_q, adc_clock_enable_q,
		hibernation_clock_enable_q, watchdog_clock_enable_q};
	// unknown unit ids fault too, nothing would answer them
	assign unit_on = (unit_id < 3'(NUM_UNITS)) && pin_en[unit_id];

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			unit_ok_q <= 1'b0;
			unit_fault_q <= 1'b0;
		end else begin
			unit_ok_q <= unit_req && unit_on;
			unit_fault_q <= unit_req && !unit_on; // [R02] [R05] [R06]
		end
	end

	// ==========================================================
	// interrupt status, enable and clear
	logic [NUM_IRQ-1:0] irq_status_q;
	logic [NUM_IRQ-1:0] irq_enable_q;
	logic [NUM_IRQ-1:0] irq_event;
	logic deep_entry;

	assign deep_entry = (mode_d == DSCG_DEEP) && (mode_q != DSCG_DEEP);
	assign irq_event[IRQ_ACCESS_FAULT] = unit_req && !unit_on;
	assign irq_event[IRQ_DEEP_ENTRY] = deep_entry;

	// an event in the clearing cycle stays set
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_status_q <= '0;
		end else begin
			irq_status_q <= (irq_status_q & ~(wr_irq_clr ? reg_wdata[NUM_IRQ-1:0] : '0))
				| irq_event;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_enable_q <= '0;
		end else if (wr_irq_en) begin
			irq_enable_q <= reg_wdata[NUM_IRQ-1:0];
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(irq_status_q & irq_enable_q);
		end
	end

	// ==========================================================
	// read path, zero for unmapped and write-only offsets
	logic [31:0] rd_word;

	always_comb begin
		rd_word = 32'h0000_0000;
		case (reg_addr)
			OFF_RUN_CLOCK_CONFIG: rd_word[BIT_AUTO_GATING_SELECT] = auto_gating_select_q;
			OFF_RUN_CLOCK_GATE_0: rd_word = run_clock_gate_0;
			OFF_SLEEP_CLOCK_GATE_0: rd_word = sleep_clock_gate_0;
			OFF_DEEP_SLEEP_CLOCK_GATE_0: rd_word = deep_sleep_clock_gate_0; // [R08]
			OFF_IRQ_STATUS: rd_word[NUM_IRQ-1:0] = irq_status_q;
			OFF_IRQ_ENABLE: rd_word[NUM_IRQ-1:0] = irq_enable_q;
			default: rd_word = 32'h0000_0000;
		endcase
	end

	// data stand only in the cycle after the strobe
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata_q <= 32'h0000_0000;
		end else begin
			reg_rdata_q <= reg_rd ? rd_word : 32'h0000_0000;
		end
	end

	// ==========================================================
	// checks
	a_reserved_zero: assert property ( // [R08]
		@(posedge ref_clk) disable iff (!rst_n)
		reg_rd && (reg_addr == OFF_DEEP_SLEEP_CLOCK_GATE_0)
		|=> (reg_rdata_q & ~GATE_WR_MASK) == 32'h0000_0000)
		else $error("reserved gating bits read nonzero");

	a_write_readback: assert property ( // [R04] [R07]
		@(posedge ref_clk) disable iff (!rst_n)
		wr_deep ##1 (reg_rd && reg_addr == OFF_DEEP_SLEEP_CLOCK_GATE_0 && !reg_wr)
		|=> reg_rdata_q == ($past(reg_wdata, 2) & GATE_WR_MASK))
		else $error("deep gating readback mismatch");

	a_reset_word: assert property ( // [R03]
		@(posedge ref_clk) disable iff (!rst_n)
		$rose(rst_n) |-> deep_sleep_clock_gate_0 == 32'h0000_0040)
		else $error("deep gating reset word wrong");

	a_deep_applies: assert property ( // [R01] [R10]
		@(posedge ref_clk) disable iff (!rst_n)
		(mode_q == DSCG_DEEP && auto_gating_select_q && !wr_deep && !wr_run_cfg)[*2]
		|=> pwm_clock_enable_q == $past(deep_sleep_clock_gate_0[BIT_PWM], 2))
		else $error("deep gating not applied to pwm");

	a_run_holds: assert property ( // [R10]
		@(posedge ref_clk) disable iff (!rst_n)
		(!auto_gating_select_q && !wr_run)[*2]
		|=> watchdog_clock_enable_q == $past(run_clock_gate_0[BIT_WDT], 2))
		else $error("run gating not in force without select");

	a_wdt_fault: assert property ( // [R05]
		@(posedge ref_clk) disable iff (!rst_n)
		unit_req && unit_id == UNIT_WDT && !watchdog_clock_enable_q
		|=> unit_fault_q && !unit_ok_q)
		else $error("watchdog access without clock did not fault");

	a_pwm_fault: assert property ( // [R06]
		@(posedge ref_clk) disable iff (!rst_n)
		unit_req && unit_id == UNIT_PWM && !pwm_clock_enable_q
		|=> unit_fault_q && !unit_ok_q)
		else $error("pwm access without clock did not fault");

	a_fault_cause: assert property ( // [R02]
		@(posedge ref_clk) disable iff (!rst_n)
		unit_fault_q |-> $past(unit_req) && !unit_ok_q)
		else $error("fault without request or together with grant");

	a_grant_clocked: assert property ( // [R01]
		@(posedge ref_clk) disable iff (!rst_n)
		unit_req && unit_id == UNIT_CAN && can_unit_clock_enable_q
		|=> unit_ok_q && !unit_fault_q)
		else $error("clocked can access refused");

	a_irq_sticky: assert property (
		@(posedge ref_clk) disable iff (!rst_n)
		unit_req && !unit_on |=> irq_status_q[IRQ_ACCESS_FAULT])
		else $error("fault event lost from status");

	a_hib_reset: assert property ( // [R04]
		@(posedge ref_clk) disable iff (!rst_n)
		$rose(rst_n) |-> hibernation_clock_enable_q && deep_sleep_clock_gate_0[BIT_HIB])
		else $error("hibernation enable clear after reset");

	a_pins_reset: assert property ( // [R03]
		@(posedge ref_clk) disable iff (!rst_n)
		$rose(rst_n) |-> !can_unit_clock_enable_q && !pwm_clock_enable_q
			&& !adc_clock_enable_q && !watchdog_clock_enable_q)
		else $error("gated unit enabled straight after reset");

	a_adc_fault: assert property ( // [R07]
		@(posedge ref_clk) disable iff (!rst_n)
		unit_req && unit_id == UNIT_ADC && !adc_clock_enable_q
		|=> unit_fault_q && !unit_ok_q)
		else $error("adc access without clock did not fault");

	a_can_fault: assert property ( // [R07]
		@(posedge ref_clk) disable iff (!rst_n)
		unit_req && unit_id == UNIT_CAN && !can_unit_clock_enable_q
		|=> unit_fault_q && !unit_ok_q)
		else $error("can access without clock did not fault");

	a_hib_fault: assert property ( // [R02]
		@(posedge ref_clk) disable iff (!rst_n)
		unit_req && unit_id == UNIT_HIB && !hibernation_clock_enable_q
		|=> unit_fault_q && !unit_ok_q)
		else $error("hibernation access without clock did not fault");

	a_adc_grant: assert property ( // [R01]
		@(posedge ref_clk) disable iff (!rst_n)
		unit_req && unit_id == UNIT_ADC && adc_clock_enable_q
		|=> unit_ok_q && !unit_fault_q)
		else $error("clocked adc access refused");

	a_sleep_applies: assert property ( // [R09] [R10]
		@(posedge ref_clk) disable iff (!rst_n)
		mode_q == DSCG_SLEEP && auto_gating_select_q
		|-> ##2 watchdog_clock_enable_q == $past(sleep_clock_gate_0[BIT_WDT], 2))
		else $error("sleep gating not applied to watchdog");

	a_run_auto: assert property ( // [R10]
		@(posedge ref_clk) disable iff (!rst_n)
		mode_q == DSCG_RUN && auto_gating_select_q
		|-> ##2 hibernation_clock_enable_q == $past(run_clock_gate_0[BIT_HIB], 2))
		else $error("run gating not in force in run mode");

endmodule : dscg_top

// ---- tb/dscg_unit_model.sv ----
// behavioural model of the gated peripheral units
`timescale 1ns/10ps
module dscg_unit_model import dscg_pkg::*; (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// clock enables from the gating block
	input wire logic [NUM_UNITS-1:0] unit_en,
	// activity seen per unit
	output logic [NUM_UNITS-1:0] alive_q
);
	// ==========================================================
	// unit activity
	// a unit without clock freezes, so its toggle stands still
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			alive_q <= '0;
		end else begin
			alive_q <= alive_q ^ unit_en;
		end
	end
endmodule : dscg_unit_model

// ---- tb/dscg_top_tb.sv ----
// self-checking testbench of the deep-sleep clock gating block
`timescale 1ns/10ps
module dscg_top_tb import dscg_pkg::*;;
	// ==========================================================
	// signals
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [11:0] reg_addr = 12'h000;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata_q;
	logic sleep_req = 1'b0;
	logic deep_sleep_req = 1'b0;
	logic unit_req = 1'b0;
	logic [2:0] unit_id = 3'h0;
	logic unit_ok_q, unit_fault_q, irq_q;
	logic can_en, pwm_en, adc_en, hib_en, wdt_en;
	logic [4:0] en5;
	logic [4:0] alive_q;
	int bad_count = 0;
	int checked = 0;

	assign en5 = {can_en, pwm_en, adc_en, hib_en, wdt_en};

	always #25 ref_clk = ~ref_clk;

	dscg_top dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
		.sleep_req(sleep_req), .deep_sleep_req(deep_sleep_req), .unit_req(unit_req),
		.unit_id(unit_id), .unit_ok_q(unit_ok_q), .unit_fault_q(unit_fault_q),
		.can_unit_clock_enable_q(can_en), .pwm_clock_enable_q(pwm_en),
		.adc_clock_enable_q(adc_en), .hibernation_clock_enable_q(hib_en),
		.watchdog_clock_enable_q(wdt_en), .irq_q(irq_q));

	dscg_unit_model model_u (.ref_clk(ref_clk), .rst_n(rst_n), .unit_en(en5),
		.alive_q(alive_q));

	// ==========================================================
	// tasks
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		chk("read data", reg_rdata_q, exp);
	endtask : rd

	// write then read back with no gap between the strobes
	task automatic wr_rd(input logic [11:0] a, input logic [31:0] d, input logic [31:0] exp);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		chk("readback", reg_rdata_q, exp);
	endtask : wr_rd

	task automatic acc(input logic [2:0] id, input logic fault);
		@(posedge ref_clk);
		unit_id <= id;
		unit_req <= 1'b1;
		@(posedge ref_clk);
		unit_req <= 1'b0;
		#1;
		chk("unit fault", {31'h0, unit_fault_q}, {31'h0, fault});
		chk("unit ok", {31'h0, unit_ok_q}, {31'h0, ~fault});
	endtask : acc

	// mode and register changes reach the pins within three edges
	task automatic settle();
		repeat (4) @(posedge ref_clk);
		#1;
	endtask : settle

	task automatic en_chk(input logic [4:0] exp);
		logic [4:0] a;
		chk("enables", {27'h0, en5}, {27'h0, exp});
		a = alive_q;
		@(posedge ref_clk);
		#1;
		chk("unit clocks", {27'h0, alive_q ^ a}, {27'h0, exp});
	endtask : en_chk

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_of_test

	// ==========================================================
	// watchdog
	initial begin
		#(50 * 3000);
		bad_count++;
		end_of_test();
	end

	// ==========================================================
	// tests
	initial begin
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		#1;
		en_chk(5'h02);
		rd(OFF_DEEP_SLEEP_CLOCK_GATE_0, 32'h0000_0040);
		rd(OFF_RUN_CLOCK_GATE_0, 32'h0000_0040);
		rd(OFF_SLEEP_CLOCK_GATE_0, 32'h0000_0040);
		acc(UNIT_WDT[2:0], 1'b1);
		acc(UNIT_HIB[2:0], 1'b0);
		// units enabled before the accesses below
		wr(OFF_DEEP_SLEEP_CLOCK_GATE_0, 32'hFFFF_FFFF);
		rd(OFF_DEEP_SLEEP_CLOCK_GATE_0, 32'h0111_0048);
		wr(OFF_SLEEP_CLOCK_GATE_0, 32'h0010_0008);
		@(posedge ref_clk);
		deep_sleep_req <= 1'b1;
		settle();
		en_chk(5'h02);
		wr(OFF_RUN_CLOCK_CONFIG, 32'h0800_0000);
		settle();
		en_chk(5'h1F);
		for (int i = 0; i < 5; i++) begin
			acc(3'(i), 1'b0);
		end
		acc(3'h5, 1'b1);
		@(posedge ref_clk);
		deep_sleep_req <= 1'b0;
		sleep_req <= 1'b1;
		settle();
		en_chk(5'h09);
		acc(UNIT_CAN[2:0], 1'b1);
		acc(UNIT_HIB[2:0], 1'b1);
		acc(UNIT_PWM[2:0], 1'b0);
		wr(OFF_SLEEP_CLOCK_GATE_0, 32'h0000_0040);
		settle();
		acc(UNIT_PWM[2:0], 1'b1);
		acc(UNIT_ADC[2:0], 1'b1);
		// interrupt: enable, read, clear, raise again, mask
		wr(OFF_IRQ_ENABLE, 32'h0000_0001);
		settle();
		chk("irq", {31'h0, irq_q}, 32'h1);
		rd(OFF_IRQ_STATUS, 32'h0000_0003);
		wr(OFF_IRQ_CLEAR, 32'h0000_0003);
		settle();
		chk("irq", {31'h0, irq_q}, 32'h0);
		rd(OFF_IRQ_STATUS, 32'h0000_0000);
		acc(UNIT_CAN[2:0], 1'b1);
		@(posedge ref_clk);
		#1;
		chk("irq", {31'h0, irq_q}, 32'h1);
		wr(OFF_IRQ_ENABLE, 32'h0000_0000);
		settle();
		chk("irq", {31'h0, irq_q}, 32'h0);
		rd(OFF_IRQ_CLEAR, 32'h0000_0000);
		wr(12'h300, 32'hFFFF_FFFF);
		rd(12'h300, 32'h0000_0000);
		// back to run mode with auto select still set
		@(posedge ref_clk);
		sleep_req <= 1'b0;
		settle();
		en_chk(5'h02);
		wr_rd(OFF_DEEP_SLEEP_CLOCK_GATE_0, 32'h0100_0040, 32'h0100_0040);
		// reset in mid-run brings every register back
		@(posedge ref_clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		#1;
		en_chk(5'h02);
		rd(OFF_DEEP_SLEEP_CLOCK_GATE_0, 32'h0000_0040);
		rd(OFF_RUN_CLOCK_CONFIG, 32'h0000_0000);
		end_of_test();
	end
endmodule : dscg_top_tb
